/* logic/fct_cfg.svh */
`ifndef FCT_CFG_SVH
`define FCT_CFG_SVH

// register offsets on the plain port
`define FCT_REG_SPEC0 8'h00
`define FCT_REG_SPEC1 8'h01
`define FCT_REG_CONFIG 8'h02
`define FCT_REG_PRECOMP 8'h03
`define FCT_REG_RATE 8'h04
`define FCT_REG_TARGET 8'h05
`define FCT_REG_RELCOUNT 8'h06
`define FCT_REG_CMD 8'h07
`define FCT_REG_STATUS 8'h08
`define FCT_REG_PCYL 8'h09
`define FCT_REG_VERSION 8'h0a

// command codes written to the command register, bit 6 is the direction
`define FCT_CMD_SEEK 3'h1
`define FCT_CMD_RELSEEK 3'h2
`define FCT_CMD_RECAL 3'h3
`define FCT_CMD_RW_START 3'h4
`define FCT_CMD_RW_END 3'h5
`define FCT_CMD_SENSE 3'h6
`define FCT_CMD_DIR_BIT 6

// configure defaults: no implied seek, queue off, polling on, depth 1, track 0
`define FCT_CFG_RESET 8'h40
`define FCT_PRECOMP_RESET 8'h00

// timing
`define FCT_CLK_NS 50
`define FCT_TICK_2M_NS 125000
`define FCT_STEP_PULSE_NS 400
`define FCT_STEP_PULSE_CYC ((`FCT_STEP_PULSE_NS + `FCT_CLK_NS - 1) / `FCT_CLK_NS)
`define FCT_RECAL_MAX_STEPS 8'h50
`define FCT_STEP_TICKS_PER_CODE 6'h02
`define FCT_LOAD_TICKS_PER_CODE 10'h004
`define FCT_UNLOAD_TICKS_PER_CODE 10'h020
`define FCT_LOAD_ZERO_TICKS 10'h200

`endif

/* logic/fct_pkg.sv */
package fct_pkg;

  typedef enum logic [2:0] {RATE_500K, RATE_300K, RATE_250K, RATE_1M, RATE_2M} fct_rate_e;

  typedef enum {SK_IDLE, SK_EVAL, SK_PULSE, SK_WAIT} fct_seek_e;

  typedef enum {HD_UNLOADED, HD_SEEK, HD_LOAD, HD_READY, HD_HOLD} fct_head_e;

  typedef enum {KIND_SEEK, KIND_REL, KIND_RECAL} fct_kind_e;

  typedef struct packed {
    logic [3:0] stepCode;
    logic [3:0] unloadCode;
    logic [6:0] loadCode;
    logic noDma;
  } fct_spec_s;

  typedef struct packed {
    logic impliedSeek;
    logic queueDisable;
    logic pollDisable;
    logic unused;
    logic [3:0] threshold;
  } fct_cfg_s;

  typedef struct packed {
    logic step;
    logic dir;
    logic headLoad;
  } fct_drive_s;

endpackage : fct_pkg

/* logic/fct_cmd_timing.sv */
// Notes on behaviour
// - heads stay loaded after read/write ends until unload interval elapses.
// - unload code is 16 ms per count at 500K; code 0 means 256 ms.
// - step pulses spaced by (16 - code) ms at 500K; first gap may be shorter.
// - head load wait is 2 ms per count at 500K; code 0 means 256 ms.
// - all three timers scale inversely with data rate, same for both encodings.
// - no-DMA bit one selects non-DMA, zero selects DMA.
// - DMA mode raises DMA request; non-DMA uses request flag plus interrupt.
// - defaults: no implied seek, queue off, polling on, depth 1, precomp track 0.
// - implied seek enabled seeks to target before each read or write; here only when the heads are unloaded, not from the hold state.
// - queue disabled requests transfers one byte at a time.
// - polling gives one interrupt after reset, held off while heads loaded.
// - threshold field plus one is queue depth during read/write.
// - precompensation applies from the programmed eight-bit start track.
// - version command returns one fixed identification byte.
// - relative seek issues count pulses without comparing, still advances cylinder.
// - relative seek direction zero steps outward, one steps inward.
// - only one relative seek active at a time; host must not overlap them.
// - relative seek stepping outward past track zero sets equipment check.
// - cylinder after relative seek is old value plus count modulo 256; outward seeks subtract the count instead.
// - relative seek count up to 255 tracks.
// - recalibrate steps to track zero, at most 80 pulses, else error.
// - cylinder never records beyond 255; commands use the wrapped value.
// - normal seek compares after each step; equal sets seek end and stops.
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "fct_cfg.svh"

module fct_cmd_timing
  import fct_pkg::*;
#(
  parameter int TICK_2M_CYC = `FCT_TICK_2M_NS / `FCT_CLK_NS,
  parameter logic [7:0] VERSION_ID = 8'h5a // arbitrary identification value
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [7:0] rdData,
  // drive side
  input wire logic trackZeroPin,
  output fct_drive_s drive,
  // data path side
  input wire logic byteReady,
  input wire logic [4:0] queueLevel,
  output logic [4:0] queueDepth,
  output logic queueBypass,
  output logic rwReady,
  output logic precompActive,
  output logic diskDmaRequest,
  output logic hostTransferRequestFlag,
  output logic intReq
);

  fct_spec_s spec;
  fct_cfg_s cfg;
  logic [7:0] precompStartTrack;
  fct_rate_e rate;
  logic [7:0] targetCylinder;
  logic [7:0] relativeStepCount;
  logic [7:0] presentCylinder;
  logic seekEndFlag;
  logic equipmentCheckFlag;
  logic seekIrq;
  logic pollIrq;
  logic pollDone;
  logic trkMeta;
  logic trackZero;
  fct_seek_e seekState;
  fct_kind_e kind;
  logic stepDir;
  logic [7:0] stepsLeft;
  logic [7:0] stepsDone;
  logic [3:0] pulseCnt;
  logic [5:0] stepTmr;
  fct_head_e headState;
  logic [9:0] headTmr;
  logic [14:0] tickCnt;
  logic [14:0] tickLimit;
  logic tick;
  logic cmdWr;
  logic [2:0] cmdCode;
  logic startSeek;
  logic startRel;
  logic startRecal;
  logic startImplied;
  logic seekBusy;
  logic seekFinish;
  logic setSe;
  logic setEc;
  logic xferNeed;
  logic [9:0] next_loadTicks;
  logic [9:0] next_unloadTicks;
  logic [5:0] next_stepTicks;

  // track zero comes from the drive cable: two flops before use
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      trkMeta <= 1'b0;
      trackZero <= 1'b0;
    end
    else if (ce)
    begin
      trkMeta <= trackZeroPin;
      trackZero <= trkMeta;
    end
  end

  // tick period doubles as rate halves, so one code gives one table row
  always_comb
  begin
    case (rate)
      RATE_2M: tickLimit = 15'(TICK_2M_CYC);
      RATE_1M: tickLimit = 15'(TICK_2M_CYC * 2);
      RATE_500K: tickLimit = 15'(TICK_2M_CYC * 4);
      RATE_300K: tickLimit = 15'(TICK_2M_CYC * 20 / 3);
      RATE_250K: tickLimit = 15'(TICK_2M_CYC * 8);
      default: tickLimit = 15'(TICK_2M_CYC * 4);
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      tickCnt <= 15'h0000;
    else if (ce)
      tickCnt <= tick ? 15'h0000 : tickCnt + 15'h0001;
  end

  assign tick = (tickCnt >= tickLimit - 15'h0001);

  // interval lengths in ticks; one extra tick covers a partial first tick
  always_comb
  begin
    next_stepTicks = 6'((6'h10 - {2'h0, spec.stepCode}) * `FCT_STEP_TICKS_PER_CODE) + 6'h01;
    next_loadTicks = (spec.loadCode == 7'h00) ? `FCT_LOAD_ZERO_TICKS
      : 10'({3'h0, spec.loadCode} * `FCT_LOAD_TICKS_PER_CODE);
    next_loadTicks = next_loadTicks + 10'h001;
    next_unloadTicks = (spec.unloadCode == 4'h0) ? `FCT_LOAD_ZERO_TICKS
      : 10'({6'h00, spec.unloadCode} * `FCT_UNLOAD_TICKS_PER_CODE);
    next_unloadTicks = next_unloadTicks + 10'h001;
  end

  // register writes
  assign cmdWr = wrStb && (addr == `FCT_REG_CMD);
  assign cmdCode = wrData[2:0];
  assign seekBusy = (seekState != SK_IDLE);
  // a second seek of any kind is dropped while the stepper is busy
  assign startSeek = cmdWr && (cmdCode == `FCT_CMD_SEEK) && !seekBusy;
  assign startRel = cmdWr && (cmdCode == `FCT_CMD_RELSEEK) && !seekBusy;
  assign startRecal = cmdWr && (cmdCode == `FCT_CMD_RECAL) && !seekBusy;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      spec <= '0;
      cfg <= `FCT_CFG_RESET;
      precompStartTrack <= `FCT_PRECOMP_RESET;
      rate <= RATE_500K;
      targetCylinder <= 8'h00;
      relativeStepCount <= 8'h00;
    end
    else if (ce && wrStb)
    begin
      case (addr)
        `FCT_REG_SPEC0: {spec.stepCode, spec.unloadCode} <= wrData;
        `FCT_REG_SPEC1: {spec.loadCode, spec.noDma} <= wrData;
        `FCT_REG_CONFIG: cfg <= wrData;
        `FCT_REG_PRECOMP: precompStartTrack <= wrData;
        `FCT_REG_RATE: rate <= fct_rate_e'(wrData[2:0]);
        `FCT_REG_TARGET: targetCylinder <= wrData;
        `FCT_REG_RELCOUNT: relativeStepCount <= wrData;
        default: ;
      endcase
    end
  end

  // stepper shared by seek, relative seek, recalibrate and implied seek
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      seekState <= SK_IDLE;
      kind <= KIND_SEEK;
      stepDir <= 1'b0;
      stepsLeft <= 8'h00;
      stepsDone <= 8'h00;
      pulseCnt <= 4'h0;
      stepTmr <= 6'h00;
      presentCylinder <= 8'h00;
    end
    else if (ce)
    begin
      case (seekState)
        SK_IDLE:
        begin
          stepsDone <= 8'h00;
          if (startSeek || startImplied)
          begin
            kind <= KIND_SEEK;
            seekState <= SK_EVAL;
          end
          else if (startRel)
          begin
            kind <= KIND_REL;
            stepDir <= wrData[`FCT_CMD_DIR_BIT];
            stepsLeft <= relativeStepCount;
            seekState <= SK_EVAL;
          end
          else if (startRecal)
          begin
            kind <= KIND_RECAL;
            stepDir <= 1'b0;
            presentCylinder <= 8'h00;
            seekState <= SK_EVAL;
          end
        end
        SK_EVAL:
        begin
          if (seekFinish)
            seekState <= SK_IDLE;
          else
          begin
            seekState <= SK_PULSE;
            pulseCnt <= 4'(`FCT_STEP_PULSE_CYC - 1);
            stepsDone <= stepsDone + 8'h01;
            if (kind == KIND_SEEK)
            begin
              stepDir <= (presentCylinder < targetCylinder);
              presentCylinder <= (presentCylinder < targetCylinder) ? presentCylinder + 8'h01
                : presentCylinder - 8'h01;
            end
            else if (kind == KIND_REL)
            begin
              stepsLeft <= stepsLeft - 8'h01;
              // cylinder wraps through 255 and 0 without a note of it
              presentCylinder <= stepDir ? presentCylinder + 8'h01
                : presentCylinder - 8'h01;
            end
          end
        end
        SK_PULSE:
        begin
          if (pulseCnt == 4'h0)
          begin
            seekState <= SK_WAIT;
            stepTmr <= next_stepTicks;
          end
          else
            pulseCnt <= pulseCnt - 4'h1;
        end
        SK_WAIT:
        begin
          if (stepTmr == 6'h00)
            seekState <= SK_EVAL;
          else if (tick)
            stepTmr <= stepTmr - 6'h01;
        end
        default: seekState <= SK_IDLE;
      endcase
    end
  end

  // termination checks made before every pulse
  always_comb
  begin
    seekFinish = 1'b0;
    setSe = 1'b0;
    setEc = 1'b0;
    if (seekState == SK_EVAL)
    begin
      case (kind)
        KIND_SEEK:
        begin
          seekFinish = (presentCylinder == targetCylinder);
          setSe = seekFinish;
        end
        KIND_REL:
        begin
          setEc = !stepDir && trackZero && (stepsLeft != 8'h00);
          seekFinish = setEc || (stepsLeft == 8'h00);
          setSe = seekFinish;
        end
        KIND_RECAL:
        begin
          setEc = !trackZero && (stepsDone == `FCT_RECAL_MAX_STEPS);
          seekFinish = trackZero || setEc;
          setSe = seekFinish;
        end
        default: seekFinish = 1'b1;
      endcase
    end
  end

  // status flags: a hardware set beats a same-cycle sense clear
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      seekEndFlag <= 1'b0;
      equipmentCheckFlag <= 1'b0;
      seekIrq <= 1'b0;
    end
    else if (ce)
    begin
      if (setSe || setEc)
      begin
        seekEndFlag <= setSe;
        equipmentCheckFlag <= setEc;
        seekIrq <= (headState != HD_SEEK);
      end
      else if (cmdWr && (cmdCode == `FCT_CMD_SENSE))
      begin
        seekEndFlag <= 1'b0;
        equipmentCheckFlag <= 1'b0;
        seekIrq <= 1'b0;
      end
    end
  end

  // head load, ready and unload hold
  assign startImplied = (headState == HD_UNLOADED) && cmdWr && (cmdCode == `FCT_CMD_RW_START)
    && cfg.impliedSeek && !seekBusy && (presentCylinder != targetCylinder);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      headState <= HD_UNLOADED;
      headTmr <= 10'h000;
    end
    else if (ce)
    begin
      case (headState)
        HD_UNLOADED:
        begin
          if (startImplied)
            headState <= HD_SEEK;
          else if (cmdWr && (cmdCode == `FCT_CMD_RW_START) && !seekBusy)
          begin
            headState <= HD_LOAD;
            headTmr <= next_loadTicks;
          end
        end
        HD_SEEK:
        begin
          if (!seekBusy)
          begin
            headState <= HD_LOAD;
            headTmr <= next_loadTicks;
          end
        end
        HD_LOAD:
        begin
          if (headTmr == 10'h000)
            headState <= HD_READY;
          else if (tick)
            headTmr <= headTmr - 10'h001;
        end
        HD_READY:
        begin
          if (cmdWr && (cmdCode == `FCT_CMD_RW_END))
          begin
            headState <= HD_HOLD;
            headTmr <= next_unloadTicks;
          end
        end
        HD_HOLD:
        begin
          if (cmdWr && (cmdCode == `FCT_CMD_RW_START))
            headState <= HD_READY;
          else if (headTmr == 10'h000)
            headState <= HD_UNLOADED;
          else if (tick)
            headTmr <= headTmr - 10'h001;
        end
        default: headState <= HD_UNLOADED;
      endcase
    end
  end

  // one poll interrupt per reset, only while the heads are unloaded
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pollIrq <= 1'b0;
      pollDone <= 1'b0;
    end
    else if (ce)
    begin
      if (!pollDone && !cfg.pollDisable && (headState == HD_UNLOADED))
      begin
        pollIrq <= 1'b1;
        pollDone <= 1'b1;
      end
      else if (cmdWr && (cmdCode == `FCT_CMD_SENSE))
        pollIrq <= 1'b0;
    end
  end

  // transfer requests
  assign queueDepth = {1'b0, cfg.threshold} + 5'h01;
  assign queueBypass = cfg.queueDisable;
  assign xferNeed = rwReady && (cfg.queueDisable ? byteReady
    : (queueLevel >= queueDepth));
  assign diskDmaRequest = xferNeed && !spec.noDma;
  assign hostTransferRequestFlag = xferNeed && spec.noDma;
  assign intReq = seekIrq || pollIrq || hostTransferRequestFlag;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      drive <= '0;
      rwReady <= 1'b0;
      precompActive <= 1'b0;
    end
    else if (ce)
    begin
      drive.step <= (seekState == SK_EVAL) && !seekFinish
        || (seekState == SK_PULSE) && (pulseCnt != 4'h0);
      drive.dir <= (seekState == SK_EVAL && kind == KIND_SEEK) ? (presentCylinder < targetCylinder)
        : stepDir;
      drive.headLoad <= (headState == HD_LOAD) || (headState == HD_READY)
        || (headState == HD_HOLD);
      rwReady <= (headState == HD_READY);
      precompActive <= (headState == HD_READY) && (presentCylinder >= precompStartTrack);
    end
  end

  // read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rdData <= 8'h00;
    else if (ce && rdStb)
    begin
      case (addr)
        `FCT_REG_SPEC0: rdData <= {spec.stepCode, spec.unloadCode};
        `FCT_REG_SPEC1: rdData <= {spec.loadCode, spec.noDma};
        `FCT_REG_CONFIG: rdData <= cfg;
        `FCT_REG_PRECOMP: rdData <= precompStartTrack;
        `FCT_REG_RATE: rdData <= {5'h00, rate};
        `FCT_REG_TARGET: rdData <= targetCylinder;
        `FCT_REG_RELCOUNT: rdData <= relativeStepCount;
        `FCT_REG_STATUS: rdData <= {seekBusy, drive.headLoad, rwReady, equipmentCheckFlag,
          seekEndFlag, pollIrq, seekIrq, intReq};
        `FCT_REG_PCYL: rdData <= presentCylinder;
        `FCT_REG_VERSION: rdData <= VERSION_ID;
        default: rdData <= 8'h00;
      endcase
    end
    else if (ce)
      rdData <= 8'h00;
  end

  a_step_width: assert property (@(posedge clk) disable iff (!rst_b || !ce)
    $rose(drive.step) |-> drive.step[*8] ##1 !drive.step)
    else $error("step pulse width wrong");

  a_unload_hold: assert property (@(posedge clk) disable iff (!rst_b || !ce)
    (headState == HD_READY) && cmdWr && (cmdCode == `FCT_CMD_RW_END) |=> ##1 drive.headLoad[*8])
    else $error("heads dropped before unload interval");

  a_dma_select: assert property (@(posedge clk) disable iff (!rst_b || !ce)
    diskDmaRequest |-> !spec.noDma && !hostTransferRequestFlag)
    else $error("dma request in non-dma mode");

  a_pio_signal: assert property (@(posedge clk) disable iff (!rst_b || !ce)
    hostTransferRequestFlag |-> intReq && spec.noDma)
    else $error("non-dma request without interrupt");

  a_queue_bypass: assert property (@(posedge clk) disable iff (!rst_b || !ce)
    diskDmaRequest && cfg.queueDisable |-> byteReady && rwReady)
    else $error("bypass request without a byte");

  a_rel_wrap: assert property (@(posedge clk) disable iff (!rst_b || !ce)
    (seekState == SK_EVAL) && (kind == KIND_REL) && !seekFinish
    |=> presentCylinder == ($past(stepDir) ? 8'($past(presentCylinder) + 8'h01)
      : 8'($past(presentCylinder) - 8'h01)))
    else $error("relative seek cylinder update wrong");

  a_ec_outward: assert property (@(posedge clk) disable iff (!rst_b || !ce)
    (seekState == SK_EVAL) && (kind == KIND_REL) && !stepDir && trackZero && (stepsLeft != 8'h00)
    |=> equipmentCheckFlag && (seekState == SK_IDLE))
    else $error("no equipment check at track zero");

  a_seek_end: assert property (@(posedge clk) disable iff (!rst_b || !ce)
    (seekState == SK_EVAL) && (kind == KIND_SEEK) && (presentCylinder == targetCylinder)
    |=> seekEndFlag && !drive.step && (seekState == SK_IDLE))
    else $error("seek did not end on match");

  a_recal_limit: assert property (@(posedge clk) disable iff (!rst_b || !ce)
    (kind == KIND_RECAL) |-> stepsDone <= `FCT_RECAL_MAX_STEPS)
    else $error("recalibrate exceeded step limit");

  a_version_byte: assert property (@(posedge clk) disable iff (!rst_b || !ce)
    rdStb && (addr == `FCT_REG_VERSION) |=> rdData == VERSION_ID)
    else $error("version byte wrong");

  a_precomp_start: assert property (@(posedge clk) disable iff (!rst_b || !ce)
    precompActive |-> $past(presentCylinder) >= $past(precompStartTrack))
    else $error("precomp below start track");

endmodule : fct_cmd_timing

/* verification/fct_drive_model.sv */
`timescale 1ns/10ps
module fct_drive_model
  import fct_pkg::*;
(
  // drive lines
  input wire logic clk,
  input wire fct_drive_s drive,
  output logic trackZeroPin,
  // observation
  output int steps,
  output int lastGap,
  output logic lastDir
);
  int pos = 0;
  int cyc = 0;
  int count = 0;
  int gap = 0;
  int lastRise = 0;
  logic dirSeen = 1'b0;
  logic stepQ = 1'b0;

  // the carriage stops hard at both ends, like a real mechanism
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    stepQ <= drive.step;
    if (drive.step && !stepQ)
    begin
      count <= count + 1;
      gap <= cyc - lastRise;
      lastRise <= cyc;
      dirSeen <= drive.dir;
      if (drive.dir && pos < 299)
        pos <= pos + 1;
      else if (!drive.dir && pos > 0)
        pos <= pos - 1;
    end
  end

  assign trackZeroPin = (pos == 0);
  assign steps = count;
  assign lastGap = gap;
  assign lastDir = dirSeen;
endmodule : fct_drive_model

/* verification/floppy_cmd_timing_and_relseek_bench.sv */
`timescale 1ns/10ps
module floppy_cmd_timing_and_relseek_bench
  import fct_pkg::*;
;
  localparam int TICK = 4;
  localparam logic [7:0] VID = 8'h3c; // arbitrary identification value
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wrData = 8'h00;
  logic wrStb = 1'b0;
  logic rdStb = 1'b0;
  logic [7:0] rdData;
  logic trackZeroPin;
  fct_drive_s drive;
  logic byteReady = 1'b0;
  logic [4:0] queueLevel = 5'h00;
  logic [4:0] queueDepth;
  logic queueBypass, rwReady, precompActive, diskDmaRequest, hostTransferRequestFlag, intReq;
  int steps, lastGap, failures = 0, comparisons = 0, cycles = 0;
  logic lastDir;

  fct_cmd_timing #(.TICK_2M_CYC(TICK), .VERSION_ID(VID)) u_dut (.clk(clk), .rst_b(rst_b),
    .ce(ce), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
    .trackZeroPin(trackZeroPin), .drive(drive), .byteReady(byteReady), .queueLevel(queueLevel),
    .queueDepth(queueDepth), .queueBypass(queueBypass), .rwReady(rwReady),
    .precompActive(precompActive), .diskDmaRequest(diskDmaRequest),
    .hostTransferRequestFlag(hostTransferRequestFlag), .intReq(intReq));

  fct_drive_model u_drive (.clk(clk), .drive(drive), .trackZeroPin(trackZeroPin),
    .steps(steps), .lastGap(lastGap), .lastDir(lastDir));

  always #25 clk = ~clk;

  task automatic close_out;
    begin
      if (failures == 0 && comparisons > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask : close_out

  // expected run is about 30k cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      failures++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
      comparisons++;
      if (got !== exp)
      begin
        failures++;
        $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
    end
  endtask : chk

  task automatic chkIn(input string what, input int lo, input int hi, input int got);
    begin
      comparisons++;
      if (got < lo || got > hi)
      begin
        failures++;
        $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
    end
  endtask : chkIn

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wrData <= d;
      wrStb <= 1'b1;
      @(posedge clk);
      wrStb <= 1'b0;
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      rdStb <= 1'b1;
      @(posedge clk);
      rdStb <= 1'b0;
      #1;
      d = rdData;
    end
  endtask : rd

  task automatic settle(input int n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask : settle

  // runs a stepper command to the end, returns status, then senses it away
  task automatic cmdRun(input logic [7:0] c, input int expSteps, input logic [7:0] expCyl,
    output logic [7:0] st);
    int s0;
    int n;
    begin
      s0 = steps;
      wr(8'h07, c);
      n = 0;
      st = 8'h80;
      while (st[7] !== 1'b0 && n < 20000)
      begin
        rd(8'h08, st);
        n++;
      end
      chk("idle", 1'b0, st[7]);
      chk("steps", expSteps, steps - s0);
      rd(8'h09, st);
      chk("cylinder", expCyl, st);
      chk("seekIrq", 1'b1, intReq);
      rd(8'h08, st);
      wr(8'h07, 8'h06);
    end
  endtask : cmdRun

  task automatic tDefaults;
    logic [7:0] v;
    begin
      settle(3);
      chk("pollIrq", 1'b1, intReq);
      rd(8'h02, v);
      chk("config", 8'h40, v);
      chk("depth", 5'h01, queueDepth);
      chk("bypass", 1'b1, queueBypass);
      rd(8'h03, v);
      chk("precomp", 8'h00, v);
      rd(8'h0a, v);
      chk("version", VID, v);
      rd(8'hff, v);
      chk("unmapped", 8'h00, v);
      wr(8'h07, 8'h06);
      wr(8'h02, 8'h0f);
      settle(1);
      chk("irqCleared", 1'b0, intReq);
      chk("depth", 5'h10, queueDepth);
      chk("bypass", 1'b0, queueBypass);
      wr(8'h02, 8'h40);
      wr(8'h00, 8'hf1);
    end
  endtask : tDefaults

  task automatic tRates;
    fct_rate_e rl[4] = '{RATE_2M, RATE_1M, RATE_500K, RATE_250K};
    int tc[4] = '{TICK, 2 * TICK, 4 * TICK, 8 * TICK};
    logic [7:0] st;
    begin
      wr(8'h06, 8'h01);
      cmdRun(8'h02, 0, 8'h00, st);
      chk("equipCheck", 1'b1, st[4]);
      for (int i = 0; i < 4; i++)
      begin
        wr(8'h04, {5'h00, rl[i]});
        wr(8'h06, 8'h03);
        cmdRun(8'h42, 3, 8'h03, st);
        chk("dirIn", 1'b1, lastDir);
        chkIn("stepGap", 2 * tc[i], 3 * tc[i] + 12, lastGap);
        wr(8'h06, 8'h03);
        cmdRun(8'h02, 3, 8'h00, st);
        chk("dirOut", 1'b0, lastDir);
      end
      wr(8'h04, 8'h00);
    end
  endtask : tRates

  task automatic tSeekWrap;
    logic [7:0] st;
    begin
      wr(8'h05, 8'h05);
      cmdRun(8'h01, 5, 8'h05, st);
      chk("seekEnd", 1'b1, st[3]);
      wr(8'h06, 8'hff);
      cmdRun(8'h42, 255, 8'h04, st);
      wr(8'h06, 8'hff);
      cmdRun(8'h02, 255, 8'h05, st);
      cmdRun(8'h03, 5, 8'h00, st);
      chk("recalEquip", 1'b0, st[4]);
      chk("atTrackZero", 1'b1, trackZeroPin);
    end
  endtask : tSeekWrap

  task automatic tHeadXfer;
    int n;
    begin
      wr(8'h01, 8'h02);
      wr(8'h07, 8'h04);
      n = 0;
      while (rwReady !== 1'b1 && n < 400)
      begin
        settle(1);
        n++;
      end
      chkIn("loadWait", 64, 90, n);
      chk("precompOn", 1'b1, precompActive);
      wr(8'h03, 8'h01);
      settle(2);
      chk("precompOff", 1'b0, precompActive);
      @(posedge clk);
      byteReady <= 1'b1;
      settle(2);
      chk("dmaReq", 1'b1, diskDmaRequest);
      chk("hostFlag", 1'b0, hostTransferRequestFlag);
      wr(8'h01, 8'h03);
      settle(2);
      chk("dmaReqOff", 1'b0, diskDmaRequest);
      chk("hostFlagOn", 1'b1, hostTransferRequestFlag);
      chk("xferIrq", 1'b1, intReq);
      @(posedge clk);
      byteReady <= 1'b0;
      queueLevel <= 5'h03;
      wr(8'h02, 8'h03);
      settle(1);
      chk("belowDepth", 1'b0, hostTransferRequestFlag);
      @(posedge clk);
      queueLevel <= 5'h04;
      settle(1);
      chk("atDepth", 1'b1, hostTransferRequestFlag);
      @(posedge clk);
      queueLevel <= 5'h00;
      wr(8'h02, 8'h40);
      wr(8'h07, 8'h05);
      n = 0;
      while (drive.headLoad === 1'b1 && n < 2000)
      begin
        settle(1);
        n++;
      end
      chkIn("unloadHold", 512, 545, n);
      wr(8'h02, 8'hc0);
      n = steps;
      wr(8'h07, 8'h04);
      settle(900);
      chk("impliedSteps", 5, steps - n);
      chk("impliedReady", 1'b1, rwReady);
    end
  endtask : tHeadXfer

  initial
  begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    tDefaults();
    tRates();
    tSeekWrap();
    tHeadXfer();
    close_out();
  end
endmodule : floppy_cmd_timing_and_relseek_bench
